// ### tci_host.sv
/* Bus master model driving clock and data lines.
   Assumes the bench resolves open-drain levels. */
`default_nettype none
module tci_host (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int q = 8;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic half();
    repeat (q) @(posedge clk);
  endtask
  task automatic rise();
    int n = 0;
    scl_o <= 1'b1;
    @(posedge clk);
    while (scl !== 1'b1 && n < 20000) begin // Wait out stretching
      @(posedge clk);
      n++;
    end
    half();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    half();
    rise();
    r = sda;
    half();
    scl_o <= 1'b0;
    half();
  endtask
  task automatic start();
    sda_o <= 1'b1;
    half();
    rise();
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda_o <= 1'b0;
    half();
    rise();
    sda_o <= 1'b1;
    half();
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask
endmodule
`default_nettype wire

// ### tci_pkg.sv
/*
  Package for the touch controller two-wire target: bus constants,
  command codes, channel codes, register map bounds and carriers.
  Assumes a 100 MHz system clock and synchronous bus pin inputs.
*/
`default_nettype none
package tci_pkg;
  localparam logic [5:0] TARGET_ID_BASE = 6'h24;
  localparam logic [3:0] CMD_SELECT = 4'ha;
  localparam logic [3:0] CMD_CONVERT = 4'hb;
  localparam logic [3:0] CMD_HOST_DRIVEN = 4'hc;
  localparam logic [3:0] CMD_PEN_DETECT = 4'hd;
  localparam logic [3:0] CMD_PEN_TRIGGER = 4'he;
  localparam logic [1:0] CTRL_WRITE = 2'h0;
  localparam logic [1:0] CTRL_READ = 2'h1;
  localparam logic [2:0] CHAN_X = 3'h0;
  localparam logic [2:0] CHAN_Y = 3'h1;
  localparam logic [2:0] CHAN_Z1 = 3'h2;
  localparam logic [2:0] CHAN_Z2 = 3'h3;
  localparam logic [2:0] MASKED_SET_CODE = 3'h7;
  localparam logic [5:0] REG_LAST = 6'h26;
  localparam logic [5:0] REG_ACTIVE_INPUT_MASK = 6'h04;
  localparam logic [7:0] ACTIVE_MASK_RESET = 8'hc0;
  localparam logic [15:0] INVALID_WORD = 16'hffff;
  localparam int CHAN_ID_LSB = 12;
  localparam int NUM_CHAN = 4;
  typedef enum logic [1:0] {
    MODE_HOST_DRIVEN = 2'h0,
    MODE_PEN_DETECT = 2'h1,
    MODE_PEN_TRIGGER = 2'h2
  } tci_mode_t;
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] chan;
  } tci_cmd_t;
  typedef struct packed {
    logic [15:0] word;
    logic valid;
  } tci_chan_t;
endpackage
`default_nettype wire

// ### tci_props.sv
/* Port checker for the two-wire target.
   Bound into tci_target; sees its ports only. */
`default_nettype none
module tci_props (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic sample_busy,
  input wire logic data_ready,
  input wire logic host_alert_n,
  input wire logic halt_conv,
  input wire tci_pkg::tci_cmd_t cmd_q,
  input wire logic cmd_stb_q,
  input wire tci_pkg::tci_mode_t mode_q,
  input wire logic [7:0] active_input_mask
);
  logic [3:0] gap_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Cycles since last stop
  always_ff @(posedge clk_sys) begin
    if (!resetn) gap_q <= 4'hf;
    else if (scl_in && sda_in && !$past(sda_in)) gap_q <= 4'h0;
    else if (gap_q != 4'hf) gap_q <= gap_q + 4'h1;
  end
  property p_unstretch; $fell(sample_busy) |-> ##[0:4] !scl_oe; endproperty
  a_unstretch: assert property (p_unstretch) else $error("stuck");
  property p_alert_set; data_ready |-> ##[1:2] !host_alert_n; endproperty
  a_alert_set: assert property (p_alert_set) else $error("no alert");
  property p_halt;
    cmd_stb_q && $past(halt_conv) |-> cmd_q.op == tci_pkg::CMD_SELECT;
  endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");
  property p_release; $rose(host_alert_n) |-> gap_q < 4'h8; endproperty
  a_release: assert property (p_release) else $error("early");
  property p_stb; cmd_stb_q |-> gap_q < 4'h8; endproperty
  a_stb: assert property (p_stb) else $error("strobe off stop");
  property p_sda_hold; $changed(sda_oe) |-> !scl_in; endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("sda moved");
  property p_reset;
    $rose(resetn) |-> !sda_oe && !scl_oe && host_alert_n &&
      active_input_mask == tci_pkg::ACTIVE_MASK_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  property p_mode;
    cmd_stb_q && host_alert_n && cmd_q.op inside {4'hc, 4'hd, 4'he} |->
      ##[0:2] mode_q == tci_pkg::tci_mode_t'(cmd_q.op[1:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  c_stretch: cover property (scl_oe);
  c_release: cover property ($rose(host_alert_n));
  c_trig: cover property (mode_q == tci_pkg::MODE_PEN_TRIGGER);
endmodule
bind tci_target tci_props tci_props_i (.clk_sys, .resetn, .scl_in, .sda_in,
  .scl_oe, .sda_oe, .sample_busy, .data_ready, .host_alert_n, .halt_conv,
  .cmd_q, .cmd_stb_q, .mode_q, .active_input_mask);
`default_nettype wire

// ### tci_target.sv
/*
  Two-wire bus target of the touch controller: address match, register
  access, command decode, channel streaming and clock stretching.
  Assumes scl and sda inputs already synchronous to clk_sys.
*/
`default_nettype none
module tci_target #(
  parameter int NUM_REGS = 39,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic addr_strap,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sample_busy,
  input wire tci_pkg::tci_chan_t chan_data [tci_pkg::NUM_CHAN],
  input wire logic data_ready,
  output logic host_alert_n,
  output logic halt_conv,
  output var tci_pkg::tci_cmd_t cmd_q,
  output logic cmd_stb_q,
  output var tci_pkg::tci_mode_t mode_q,
  output logic [7:0] active_input_mask
);
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RX = 6'b000010,
    ST_ACK = 6'b000100,
    ST_TX = 6'b001000,
    ST_RACK = 6'b010000,
    ST_STRETCH = 6'b100000
  } tci_state_t;

  tci_state_t state_q;
  logic scl_q, sda_q, strap_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic is_read_q, chan_rd_q, reg_wr_q, acked_q, stretch_pend_q, cmd_pend_q;
  logic [7:0] cmd_byte_q;
  logic [5:0] register_pointer;
  logic [7:0] regs_q [NUM_REGS];
  logic [2:0] last_conv_q;
  logic [2:0] ch_idx_q;
  logic byte_hi_q, chan_done_q, alert_q;
  logic [15:0] buf_q [BUF_DEPTH];
  logic [1:0] buf_cnt_q;
  logic buf_rd_q, buf_wr_q;
  logic start_c, stop_c, scl_rise, scl_fall, buf_in_valid, buf_in_ready;
  logic buf_out_valid, buf_out_ready;
  logic [15:0] next_word;
  logic [3:0] readable;
  logic [2:0] nxt_ch;
  logic [6:0] my_addr;

  assign start_c = scl_in && scl_q && sda_q && !sda_in;
  assign stop_c = scl_in && scl_q && !sda_q && sda_in;
  assign scl_rise = scl_in && !scl_q;
  assign scl_fall = !scl_in && scl_q;
  assign my_addr = {tci_pkg::TARGET_ID_BASE, strap_q};
  assign active_input_mask = regs_q[tci_pkg::REG_ACTIVE_INPUT_MASK];
  assign host_alert_n = !alert_q;
  assign halt_conv = alert_q;
  assign scl_out = 1'b0;
  assign scl_oe = (state_q == ST_STRETCH);

  // Readable set: manual mode uses last convert, else the mask
  always_comb begin
    readable = active_input_mask[7:4];
    if (mode_q == tci_pkg::MODE_HOST_DRIVEN) begin
      readable = '0;
      if (last_conv_q == tci_pkg::MASKED_SET_CODE) begin
        readable = active_input_mask[7:4];
      end else if (!last_conv_q[2]) begin
        readable = 4'h8 >> last_conv_q[1:0];
      end
    end
  end

  // Next enabled channel in fixed order
  always_comb begin
    nxt_ch = 3'h4;
    for (int i = tci_pkg::NUM_CHAN - 1; i >= 0; i--) begin
      if (i >= int'(ch_idx_q) && readable[3 - i]) begin
        nxt_ch = 3'(i);
      end
    end
  end

  always_comb begin
    next_word = tci_pkg::INVALID_WORD;
    if (nxt_ch < 3'h4 && chan_data[nxt_ch[1:0]].valid) begin
      next_word = chan_data[nxt_ch[1:0]].word;
      next_word[14:tci_pkg::CHAN_ID_LSB] = nxt_ch;
    end
  end

  // Two-entry word buffer between channel select and shifter
  assign buf_in_valid = chan_rd_q && nxt_ch < 3'h4;
  assign buf_in_ready = buf_cnt_q < 2'(BUF_DEPTH);
  assign buf_out_valid = buf_cnt_q != 2'h0;
  assign buf_out_ready = (state_q == ST_RACK) && scl_fall && byte_hi_q
    && chan_rd_q && acked_q;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      buf_cnt_q <= '0;
      buf_rd_q <= 1'b0;
      buf_wr_q <= 1'b0;
      ch_idx_q <= '0;
      chan_done_q <= 1'b0;
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_q[i] <= '0;
      end
    end else if (clk_en) begin
      if (start_c) begin
        buf_cnt_q <= '0;
        buf_rd_q <= 1'b0;
        buf_wr_q <= 1'b0;
        ch_idx_q <= '0;
        chan_done_q <= 1'b0;
      end else begin
        if (buf_in_valid && buf_in_ready) begin
          buf_q[buf_wr_q] <= next_word;
          buf_wr_q <= !buf_wr_q;
          ch_idx_q <= nxt_ch + 3'h1;
        end
        if (buf_out_valid && buf_out_ready) begin
          buf_rd_q <= !buf_rd_q;
        end
        buf_cnt_q <= buf_cnt_q + 2'(buf_in_valid && buf_in_ready)
          - 2'(buf_out_valid && buf_out_ready);
        if (chan_rd_q && nxt_ch == 3'h4 && buf_cnt_q == 2'h1
          && buf_out_ready) begin
          chan_done_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      strap_q <= 1'b0;
    end else if (clk_en) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      strap_q <= addr_strap;
    end
  end

  // Bus protocol engine, rate follows master's scl edges
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      shift_q <= '0;
      bit_q <= '0;
      byte_q <= '0;
      is_read_q <= 1'b0;
      chan_rd_q <= 1'b0;
      reg_wr_q <= 1'b0;
      acked_q <= 1'b0;
      stretch_pend_q <= 1'b0;
      cmd_pend_q <= 1'b0;
      cmd_byte_q <= '0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      byte_hi_q <= 1'b1;
      register_pointer <= '0;
      cmd_q <= '0;
      cmd_stb_q <= 1'b0;
      mode_q <= tci_pkg::MODE_HOST_DRIVEN;
      last_conv_q <= tci_pkg::MASKED_SET_CODE;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_q[i] <= '0;
      end
      regs_q[tci_pkg::REG_ACTIVE_INPUT_MASK] <= tci_pkg::ACTIVE_MASK_RESET;
    end else if (clk_en) begin
      cmd_stb_q <= 1'b0;
      if (start_c) begin
        state_q <= ST_RX;
        bit_q <= '0;
        byte_q <= '0;
        chan_rd_q <= 1'b0;
        sda_oe <= 1'b0;
        byte_hi_q <= 1'b1;
        cmd_pend_q <= 1'b0;
      end else if (stop_c) begin
        state_q <= ST_IDLE;
        sda_oe <= 1'b0;
        if (cmd_pend_q) begin
          cmd_q <= '{op: cmd_byte_q[7:4], chan: cmd_byte_q[2:0]};
          cmd_stb_q <= !alert_q || cmd_byte_q[7:4] == tci_pkg::CMD_SELECT;
          if (!alert_q) begin
            unique case (cmd_byte_q[7:4])
              tci_pkg::CMD_HOST_DRIVEN: mode_q <= tci_pkg::MODE_HOST_DRIVEN;
              tci_pkg::CMD_PEN_DETECT: mode_q <= tci_pkg::MODE_PEN_DETECT;
              tci_pkg::CMD_PEN_TRIGGER: mode_q <= tci_pkg::MODE_PEN_TRIGGER;
              tci_pkg::CMD_CONVERT: last_conv_q <= cmd_byte_q[2:0];
              default: ;
            endcase
          end
        end
        reg_wr_q <= 1'b0;
        cmd_pend_q <= 1'b0;
      end else begin
        unique case (state_q)
          ST_IDLE: ;
          ST_RX: if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_in};
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_q <= '0;
            state_q <= ST_IDLE;
            if (byte_q == 2'h0) begin
              // Only own seven-bit address, general call ignored
              if (shift_q[7:1] == my_addr) begin
                is_read_q <= shift_q[0];
                chan_rd_q <= shift_q[0] && !reg_wr_q;
                stretch_pend_q <= sample_busy && shift_q[0];
                sda_out <= 1'b0;
                sda_oe <= 1'b1;
                state_q <= ST_ACK;
                byte_q <= 2'h1;
              end
            end else begin
              stretch_pend_q <= sample_busy;
              cmd_pend_q <= byte_q == 2'h1 && shift_q[7];
              cmd_byte_q <= shift_q;
              if (byte_q == 2'h1 && shift_q[7:6] == tci_pkg::CTRL_WRITE) begin
                register_pointer <= shift_q[5:0];
                reg_wr_q <= 1'b1;
              end else if (byte_q == 2'h1
                && shift_q[7:6] == tci_pkg::CTRL_READ) begin
                register_pointer <= shift_q[5:0];
                reg_wr_q <= 1'b1;
              end else if (reg_wr_q && byte_q == 2'h2) begin
                if (register_pointer <= tci_pkg::REG_LAST) begin
                  regs_q[register_pointer] <= shift_q;
                end
                register_pointer <= register_pointer + 6'h1;
              end
              sda_out <= 1'b0;
              sda_oe <= 1'b1;
              state_q <= ST_ACK;
              byte_q <= 2'h2;
            end
          end
          ST_ACK: if (scl_fall) begin
            if (is_read_q) begin
              state_q <= stretch_pend_q ? ST_STRETCH : ST_TX;
              bit_q <= '0;
              reg_wr_q <= 1'b0;
              sda_oe <= 1'b1;
              if (chan_rd_q) begin
                shift_q <= buf_q[buf_rd_q][15:8];
              end else begin
                shift_q <= register_pointer <= tci_pkg::REG_LAST ?
                  regs_q[register_pointer] : 8'h00;
                register_pointer <= register_pointer + 6'h1;
              end
              sda_out <= chan_rd_q ? buf_q[buf_rd_q][15] :
                (register_pointer <= tci_pkg::REG_LAST ?
                regs_q[register_pointer][7] : 1'b0);
            end else begin
              state_q <= stretch_pend_q ? ST_STRETCH : ST_RX;
              sda_oe <= 1'b0;
            end
          end
          ST_STRETCH: if (!sample_busy) begin
            stretch_pend_q <= 1'b0;
            state_q <= is_read_q ? ST_TX : ST_RX;
          end
          ST_TX: if (scl_fall) begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              sda_oe <= 1'b0;
              state_q <= ST_RACK;
            end else begin
              sda_out <= shift_q[6 - bit_q[2:0]];
            end
          end
          ST_RACK: if (scl_rise) begin
            acked_q <= !sda_in;
          end else if (scl_fall) begin
            if (!acked_q) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_TX;
              bit_q <= '0;
              sda_oe <= 1'b1;
              if (chan_rd_q) begin
                byte_hi_q <= !byte_hi_q;
                shift_q <= byte_hi_q ? buf_q[buf_rd_q][7:0] :
                  buf_q[buf_rd_q][15:8];
                sda_out <= byte_hi_q ? buf_q[buf_rd_q][7] :
                  buf_q[buf_rd_q][15];
              end else begin
                shift_q <= register_pointer <= tci_pkg::REG_LAST ?
                  regs_q[register_pointer] : 8'h00;
                sda_out <= register_pointer <= tci_pkg::REG_LAST ?
                  regs_q[register_pointer][7] : 1'b0;
                register_pointer <= register_pointer + 6'h1;
              end
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Alert: set on fresh data, cleared by stop after the high byte of the last word of the readable set is acked
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      alert_q <= 1'b0;
    end else if (clk_en) begin
      if (data_ready) begin
        alert_q <= 1'b1;
      end else if (stop_c && chan_done_q) begin
        alert_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
/* Bench for tci_target with a master model on the bus.
   Assumes pull-ups on both bus lines. */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, resetn, addr_strap, sample_busy, data_ready, ack;
  logic scl_o, sda_o, scl_oe, sda_oe, sda_out, host_alert_n, halt_conv;
  logic cmd_stb_q;
  logic [7:0] active_input_mask, rd;
  tci_pkg::tci_chan_t chan_data [tci_pkg::NUM_CHAN];
  tci_pkg::tci_cmd_t cmd_q;
  tci_pkg::tci_mode_t mode_q;
  wire logic scl = scl_o & !scl_oe;
  wire logic sda = sda_o & !(sda_oe & !sda_out);
  int error_cnt = 0;
  int n_tests = 0;
  int stb_cnt = 0;
  int st_cnt = 0;
  tci_target tci_target_i (.clk_sys, .resetn, .clk_en(1'b1), .addr_strap,
    .scl_in(scl), .scl_out(), .scl_oe, .sda_in(sda), .sda_out, .sda_oe,
    .sample_busy, .chan_data, .data_ready, .host_alert_n, .halt_conv,
    .cmd_q, .cmd_stb_q, .mode_q, .active_input_mask);
  tci_host tci_host_i (.clk(clk_sys), .scl, .sda, .scl_o, .sda_o);
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (cmd_stb_q === 1'b1) stb_cnt <= stb_cnt + 1;
    if (scl_oe === 1'b1) st_cnt <= st_cnt + 1;
  end
  task automatic check(input logic [15:0] got, exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic addr(input logic [7:0] a, input logic e);
    tci_host_i.start();
    tci_host_i.send(a, ack);
    check(16'(ack), 16'(e), "addr ack");
  endtask
  task automatic wreg(input logic [5:0] p, input logic [7:0] d0, d1);
    addr(8'h90, 1'b1);
    tci_host_i.send({tci_pkg::CTRL_WRITE, p}, ack);
    tci_host_i.send(d0, ack);
    tci_host_i.send(d1, ack);
    check(16'(ack), 16'h0001, "data ack");
    tci_host_i.stop();
  endtask
  task automatic rreg(input logic [5:0] p, input logic [7:0] e0, e1);
    addr(8'h90, 1'b1);
    tci_host_i.send({tci_pkg::CTRL_READ, p}, ack);
    addr(8'h91, 1'b1);
    tci_host_i.recv(1'b1, rd);
    check(16'(rd), 16'(e0), "rd0");
    tci_host_i.recv(1'b0, rd);
    check(16'(rd), 16'(e1), "rd1");
    tci_host_i.stop();
  endtask
  task automatic t_regs();
    check(16'(active_input_mask), 16'h00c0, "mask reset");
    wreg(tci_pkg::REG_ACTIVE_INPUT_MASK, 8'hf0, 8'h5a);
    check(16'(active_input_mask), 16'h00f0, "mask");
    rreg(tci_pkg::REG_ACTIVE_INPUT_MASK, 8'hf0, 8'h5a);
    rreg(tci_pkg::REG_LAST, 8'h00, 8'h00);
    wreg(6'h30, 8'h77, 8'h66);
    rreg(6'h30, 8'h00, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_addr();
    logic [7:0] a [6] = '{8'h90, 8'h92, 8'h00, 8'hf0, 8'h92, 8'h90};
    int qs [6] = '{250, 63, 8, 8, 8, 8};
    logic [5:0] e = 6'b010001;
    for (int i = 0; i < 6; i++) begin
      addr_strap <= (i > 3);
      tci_host_i.q = qs[i]; // Standard, fast, quick
      @(posedge clk_sys);
      addr(a[i], e[i]);
      tci_host_i.stop();
    end
    addr_strap <= 1'b0;
    tci_host_i.q = 8;
    $display("t_addr done");
  endtask
  task automatic t_cmd();
    logic [7:0] c [8] = '{8'ha0, 8'ha1, 8'haa, 8'ha3, 8'hb7, 8'hd5, 8'he0,
      8'hcf};
    int n;
    for (int i = 0; i < 8; i++) begin
      n = stb_cnt;
      addr(8'h90, 1'b1);
      tci_host_i.send(c[i], ack);
      check(16'(ack), 16'h0001, "cmd ack");
      tci_host_i.stop();
      repeat (4) @(posedge clk_sys);
      check(16'(stb_cnt - n), 16'h0001, "strobe");
      check(16'(cmd_q.op), 16'(c[i][7:4]), "op");
      if (c[i][7:6] == 2'b10) begin
        check(16'(cmd_q.chan), 16'(c[i][2:0]), "ch");
      end
      if (c[i][7:6] == 2'b11) begin
        check(16'(mode_q), 16'(c[i][5:4]), "mode");
      end
    end
    $display("t_cmd done");
  endtask
  task automatic t_chan();
    logic [15:0] w [4] = '{16'h0abc, 16'h0def, 16'h0555, 16'h0042};
    logic [15:0] x [4] = '{16'h0abc, 16'h1def, 16'hffff, 16'h3042};
    logic [7:0] e;
    for (int i = 0; i < 4; i++) chan_data[i] <= '{w[i], i != 2};
    data_ready <= 1'b1;
    @(posedge clk_sys);
    data_ready <= 1'b0;
    repeat (3) @(posedge clk_sys);
    check(16'(halt_conv), 16'h0001, "halt");
    sample_busy <= 1'b1;
    fork
      begin
        repeat (600) @(posedge clk_sys);
        sample_busy <= 1'b0;
      end
    join_none
    addr(8'h91, 1'b1);
    check(16'(st_cnt != 0), 16'h0001, "stretch");
    for (int i = 0; i < 8; i++) begin
      tci_host_i.recv(i < 7, rd);
      e = i[0] ? x[i/2][7:0] : x[i/2][15:8];
      check(16'(rd), 16'(e), "ch");
    end
    check(16'(host_alert_n), 16'h0000, "alert held");
    tci_host_i.stop();
    repeat (4) @(posedge clk_sys);
    check(16'(host_alert_n), 16'h0001, "alert off");
    check(16'(halt_conv), 16'h0000, "resume");
    $display("t_chan done");
  endtask
  task automatic t_single();
    logic [7:0] c [3] = '{8'hb1, 8'hb0, 8'ha1};
    int n = stb_cnt;
    for (int i = 0; i < 3; i++) begin
      addr(8'h90, 1'b1);
      tci_host_i.send(c[i], ack);
      tci_host_i.stop();
      if (i == 0) data_ready <= 1'b1;
      @(posedge clk_sys);
      data_ready <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    check(16'(stb_cnt - n), 16'h0002, "halted");
    check(16'(cmd_q.op), 16'h000a, "select");
    addr(8'h91, 1'b1);
    tci_host_i.recv(1'b1, rd);
    check(16'(rd), 16'h001d, "y hi");
    tci_host_i.recv(1'b0, rd);
    check(16'(rd), 16'h00ef, "y lo");
    tci_host_i.stop();
    repeat (4) @(posedge clk_sys);
    check(16'(host_alert_n), 16'h0001, "single off");
    $display("t_single done");
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end
  initial begin
    resetn = 1'b0;
    addr_strap = 1'b0;
    sample_busy = 1'b0;
    data_ready = 1'b0;
    foreach (chan_data[i]) chan_data[i] = '{16'h0000, 1'b0};
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_addr();
    t_cmd();
    t_chan();
    t_single();
    complete_run();
  end
endmodule
`default_nettype wire
